// ===== src/port_pin_function_priority_mux.sv
// Module: fixed-priority pin function multiplexer for ports A, B, H, M, P and debug pin
// Function
// (RULE1) Each shared pin goes to its highest ranked enabled function.
// (RULE2) Debug pin samples mode level in reset, then is two-way debug wire.
// (RULE3) All listed port pins leave reset as general-purpose I/O.
// (RULE4) Port A frontplane top, interrupt or clock output middle, GPIO last.
// (RULE5) Port A pins 7..4 prefer frontplanes 36..33 over GPIO.
// (RULE6) Port B: backplanes 3..0 and frontplanes 39,38,37,28 over GPIO.
// (RULE7) Port H pin 2: frontplane 21, SPI clock, clock output, GPIO.
// (RULE8) Port H pin 3: frontplane 22, SPI slave select, GPIO.
// (RULE9) Port H pin 1: frontplane 20, serial transmit, SPI MOSI, GPIO.
// (RULE10) Port H pin 0: frontplane 19, serial receive, SPI MISO, GPIO.
// (RULE11) Port M pins 3..2: timer1 channels, PWM 7..6, GPIO.
// (RULE12) Port M pin 1: serial transmit, timer0 channel 3, PWM 5, GPIO.
// (RULE13) Port M pin 0: serial receive, timer0 channel 2, PWM 4, GPIO.
// (RULE14) Port P: frontplanes 7..0, PWM 7..0, GPIO.
// (RULE15) Fallback GPIO takes direction and level from port registers.
`default_nettype none
module port_pin_function_priority_mux
	import pin_mux_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// General-purpose port settings
	input wire gpio_cfg_t gpio_a,
	input wire gpio_cfg_t gpio_b,
	input wire gpio_cfg_t gpio_h,
	input wire gpio_cfg_t gpio_m,
	input wire gpio_cfg_t gpio_p,
	// LCD driver
	input wire logic [39:0] lcd_frontplane_en,
	input wire logic [39:0] lcd_frontplane_out,
	input wire logic [3:0] lcd_backplane_en,
	input wire logic [3:0] lcd_backplane_out,
	// Interrupts and clock outputs
	input wire logic irq_in_en,
	input wire logic nonmaskable_irq_en,
	input wire fn_req_t periodic_irq_clock_out,
	input wire fn_req_t free_running_clock_out,
	// SPI, mapped to port H
	input wire fn_req_t spi_clock,
	input wire fn_req_t spi_slave_select,
	input wire fn_req_t spi_mosi,
	input wire fn_req_t spi_miso,
	// Second serial interface
	input wire fn_req_t serial1_transmit_h,
	input wire fn_req_t serial1_receive_h,
	input wire fn_req_t serial1_transmit_m,
	input wire fn_req_t serial1_receive_m,
	// Timers and PWM
	input wire fn_req_t [3:2] timer1_channel,
	input wire fn_req_t [3:2] timer0_channel,
	input wire fn_req_t [7:0] pwm_channel,
	// Pads
	output pad_drive_t port_a_pin,
	output pad_drive_t port_b_pin,
	output pad_drive_t port_h_pin,
	output pad_drive_t port_m_pin,
	output pad_drive_t port_p_pin,
	// Synchronised pin levels back to core
	input wire logic [7:0] port_a_pin_in,
	output logic [7:0] port_a_level,
	// Debug pin
	input wire logic debug_pin_in,
	output logic debug_pin_out,
	output logic debug_pin_oe,
	output logic mode_select_input,
	output logic debug_rx,
	input wire logic debug_tx_out,
	input wire logic debug_tx_oe
);
	localparam fn_req_t NO_REQ = '0;

	fn_req_t [7:0] a_top, a_mid, b_top, h_top, h_mid, h_low, m_top, m_mid, m_low;
	fn_req_t [7:0] p_top, p_mid;
	pin_sel_t [7:0] a_sel, b_sel, h_sel, m_sel, p_sel;
	logic [7:0] a_meta_q, a_sync_q;
	logic dbg_meta_q, dbg_sync_q;
	logic in_reset_q;

	// ********************
	// Request assembly, top rank is an LCD segment where one exists
	// ********************
	function automatic fn_req_t lcd_req(input logic en, input logic lvl);
		lcd_req = '{en: en, oe: 1'b1, out: lvl};
	endfunction

	// Interrupt input requests claim the pin with the driver off
	function automatic fn_req_t in_req(input logic en);
		in_req = '{en: en, oe: 1'b0, out: 1'b0};
	endfunction

	always_comb begin
		a_top = '0;
		a_mid = '0;
		b_top = '0;
		h_top = '0;
		h_mid = '0;
		h_low = '0;
		m_top = '0;
		m_mid = '0;
		m_low = '0;
		p_top = '0;
		p_mid = '0;
		for (int i = 0; i < 4; i++) begin
			a_top[4 + i] = lcd_req(lcd_frontplane_en[33 + i], lcd_frontplane_out[33 + i]); // see (RULE5)
			b_top[4 + i] = lcd_req(lcd_backplane_en[i], lcd_backplane_out[i]); // see (RULE6)
			h_top[4 + i] = lcd_req(lcd_frontplane_en[23 + i], lcd_frontplane_out[23 + i]);
		end
		for (int i = 0; i < 4; i++) begin
			a_top[i] = lcd_req(lcd_frontplane_en[29 + i], lcd_frontplane_out[29 + i]); // see (RULE4)
			h_top[i] = lcd_req(lcd_frontplane_en[19 + i], lcd_frontplane_out[19 + i]);
		end
		a_mid[0] = in_req(irq_in_en); // see (RULE4)
		a_mid[1] = in_req(nonmaskable_irq_en); // see (RULE4)
		a_mid[3] = periodic_irq_clock_out; // see (RULE4)
		b_top[0] = lcd_req(lcd_frontplane_en[28], lcd_frontplane_out[28]); // see (RULE6)
		b_top[1] = lcd_req(lcd_frontplane_en[37], lcd_frontplane_out[37]);
		b_top[2] = lcd_req(lcd_frontplane_en[38], lcd_frontplane_out[38]);
		b_top[3] = lcd_req(lcd_frontplane_en[39], lcd_frontplane_out[39]);
		h_mid[0] = serial1_receive_h; // see (RULE10)
		h_low[0] = spi_miso; // see (RULE10)
		h_mid[1] = serial1_transmit_h; // see (RULE9)
		h_low[1] = spi_mosi; // see (RULE9)
		h_mid[2] = spi_clock; // see (RULE7)
		h_low[2] = free_running_clock_out; // see (RULE7)
		h_mid[3] = spi_slave_select; // see (RULE8)
		m_top[0] = serial1_receive_m; // see (RULE13)
		m_mid[0] = timer0_channel[2]; // see (RULE13)
		m_low[0] = pwm_channel[4]; // see (RULE13)
		m_top[1] = serial1_transmit_m; // see (RULE12)
		m_mid[1] = timer0_channel[3]; // see (RULE12)
		m_low[1] = pwm_channel[5]; // see (RULE12)
		m_top[2] = timer1_channel[2]; // see (RULE11)
		m_mid[2] = pwm_channel[6]; // see (RULE11)
		m_top[3] = timer1_channel[3]; // see (RULE11)
		m_mid[3] = pwm_channel[7]; // see (RULE11)
		for (int i = 0; i < 8; i++) begin
			p_top[i] = lcd_req(lcd_frontplane_en[i], lcd_frontplane_out[i]); // see (RULE14)
			p_mid[i] = pwm_channel[i]; // see (RULE14)
		end
	end

	// ********************
	// Pin cells, port M upper half is GPIO only
	// ********************
	for (genvar i = 0; i < PORT_W; i++) begin : g_pin
		pin_prio_cell u_a (.clk_sys(clk_sys), .rst(rst), .req_top(a_top[i]),
			.req_mid(a_mid[i]), .req_low(NO_REQ), .gpio_dir(gpio_a.dir[i]),
			.gpio_out(gpio_a.data[i]), .pad_oe(port_a_pin.oe[i]),
			.pad_out(port_a_pin.out[i]), .sel(a_sel[i]));
		pin_prio_cell u_b (.clk_sys(clk_sys), .rst(rst), .req_top(b_top[i]),
			.req_mid(NO_REQ), .req_low(NO_REQ), .gpio_dir(gpio_b.dir[i]),
			.gpio_out(gpio_b.data[i]), .pad_oe(port_b_pin.oe[i]),
			.pad_out(port_b_pin.out[i]), .sel(b_sel[i]));
		pin_prio_cell u_h (.clk_sys(clk_sys), .rst(rst), .req_top(h_top[i]),
			.req_mid(h_mid[i]), .req_low(h_low[i]), .gpio_dir(gpio_h.dir[i]),
			.gpio_out(gpio_h.data[i]), .pad_oe(port_h_pin.oe[i]),
			.pad_out(port_h_pin.out[i]), .sel(h_sel[i]));
		pin_prio_cell u_m (.clk_sys(clk_sys), .rst(rst), .req_top(m_top[i]),
			.req_mid(m_mid[i]), .req_low(m_low[i]), .gpio_dir(gpio_m.dir[i]),
			.gpio_out(gpio_m.data[i]), .pad_oe(port_m_pin.oe[i]),
			.pad_out(port_m_pin.out[i]), .sel(m_sel[i]));
		pin_prio_cell u_p (.clk_sys(clk_sys), .rst(rst), .req_top(p_top[i]),
			.req_mid(p_mid[i]), .req_low(NO_REQ), .gpio_dir(gpio_p.dir[i]),
			.gpio_out(gpio_p.data[i]), .pad_oe(port_p_pin.oe[i]),
			.pad_out(port_p_pin.out[i]), .sel(p_sel[i]));
	end

	// ********************
	// Port A input synchroniser, feeds the interrupt inputs
	// ********************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			a_meta_q <= 8'h00;
			a_sync_q <= 8'h00;
		end else begin
			a_meta_q <= port_a_pin_in;
			a_sync_q <= a_meta_q;
		end
	end
	assign port_a_level = a_sync_q;

	// ********************
	// Debug pin
	// ********************
	// Not reset: the strap level must already be through both stages at release
	always_ff @(posedge clk_sys) begin
		dbg_meta_q <= debug_pin_in; // see (RULE2)
		dbg_sync_q <= dbg_meta_q;
	end

	// Clocked flag marks the first cycle after release so the strap is caught there
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			in_reset_q <= 1'b1;
		end else begin
			in_reset_q <= 1'b0;
		end
	end

	// Mode level is cleared while reset lasts, loaded from the synchronised strap in the first cycle after release, then frozen
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode_select_input <= 1'b0;
		end else if (in_reset_q) begin
			mode_select_input <= dbg_sync_q; // see (RULE2)
		end
	end

	// Input only while reset holds; two-way debug wire afterwards
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			debug_pin_oe <= 1'b0; // see (RULE2)
			debug_pin_out <= 1'b0;
		end else begin
			debug_pin_oe <= debug_tx_oe; // see (RULE2)
			debug_pin_out <= debug_tx_out;
		end
	end
	assign debug_rx = dbg_sync_q;

	// ********************
	// Checks
	// ********************
	property p_reset_gpio;
		@(posedge clk_sys) $fell(rst) |-> (h_sel == '0) && (m_sel == '0) && (p_sel == '0)
			&& (a_sel == '0) && (b_sel == '0);
	endproperty
	a_reset_gpio: assert property (p_reset_gpio) else $error("pin not gpio at reset"); // see (RULE3)

	property p_debug_input_in_reset;
		@(posedge clk_sys) rst |-> !debug_pin_oe;
	endproperty
	a_debug_input_in_reset: assert property (p_debug_input_in_reset) else $error("debug driven in reset"); // see (RULE2)

	property p_mode_frozen;
		@(posedge clk_sys) disable iff (rst)
		!in_reset_q |=> $stable(mode_select_input);
	endproperty
	a_mode_frozen: assert property (p_mode_frozen) else $error("mode level changed"); // see (RULE2)

	property p_ph2_order;
		@(posedge clk_sys) disable iff (rst)
		(!lcd_frontplane_en[21] && spi_clock.en) |=> h_sel[2] == SEL_MID;
	endproperty
	a_ph2_order: assert property (p_ph2_order) else $error("spi clock not chosen"); // see (RULE7)

	property p_pm1_order;
		@(posedge clk_sys) disable iff (rst)
		(!serial1_transmit_m.en && !timer0_channel[3].en && pwm_channel[5].en)
			|=> m_sel[1] == SEL_LOW;
	endproperty
	a_pm1_order: assert property (p_pm1_order) else $error("pwm5 not chosen"); // see (RULE12)

	property p_pp_lcd;
		@(posedge clk_sys) disable iff (rst)
		lcd_frontplane_en[0] |=> p_sel[0] == SEL_TOP && port_p_pin.out[0] == $past(lcd_frontplane_out[0]);
	endproperty
	a_pp_lcd: assert property (p_pp_lcd) else $error("frontplane 0 lost"); // see (RULE14)

	property p_pb_fp28;
		@(posedge clk_sys) disable iff (rst)
		lcd_frontplane_en[28] |=> b_sel[0] == SEL_TOP && port_b_pin.oe[0];
	endproperty
	a_pb_fp28: assert property (p_pb_fp28) else $error("frontplane 28 lost"); // see (RULE6)

	property p_pa1_nonmaskable_irq_in;
		@(posedge clk_sys) disable iff (rst)
		(!lcd_frontplane_en[30] && nonmaskable_irq_en) |=> a_sel[1] == SEL_MID && !port_a_pin.oe[1];
	endproperty
	a_pa1_nonmaskable_irq_in: assert property (p_pa1_nonmaskable_irq_in) else $error("interrupt input not chosen"); // see (RULE4)
endmodule
`default_nettype wire

// ===== src/pin_mux_pkg.sv
// Package: shared types and constants for the port pin function multiplexer
`default_nettype none
package pin_mux_pkg;
	// ********************
	// Widths and reset values
	// ********************
	localparam int PORT_W = 8;
	localparam logic [7:0] GPIO_RESET_DIR = 8'h00;
	localparam logic [7:0] GPIO_RESET_OUT = 8'h00;

	// One peripheral function request at a pin: enable, drive-enable, output level
	typedef struct packed {
		logic en;
		logic oe;
		logic out;
	} fn_req_t;

	// Pad drive toward the pin ring
	typedef struct packed {
		logic [7:0] oe;
		logic [7:0] out;
	} pad_drive_t;

	// General-purpose settings of one port
	typedef struct packed {
		logic [7:0] dir;
		logic [7:0] data;
	} gpio_cfg_t;

	typedef enum logic [1:0] {
		SEL_GPIO,
		SEL_LOW,
		SEL_MID,
		SEL_TOP
	} pin_sel_t;
endpackage
`default_nettype wire

// ===== src/pin_prio_cell.sv
// Module: one pin, three ranked functions above the general-purpose fallback
`default_nettype none
module pin_prio_cell
	import pin_mux_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Ranked requests, top is highest
	input wire fn_req_t req_top,
	input wire fn_req_t req_mid,
	input wire fn_req_t req_low,
	// General-purpose fallback
	input wire logic gpio_dir,
	input wire logic gpio_out,
	// Pad side
	output logic pad_oe,
	output logic pad_out,
	output pin_sel_t sel
);
	pin_sel_t sel_d;
	logic oe_d;
	logic out_d;

	// ********************
	// Fixed-priority selection
	// ********************
	always_comb begin
		sel_d = SEL_GPIO;
		oe_d = gpio_dir; // see (RULE15)
		out_d = gpio_out; // see (RULE15)
		if (req_top.en) begin // see (RULE1)
			sel_d = SEL_TOP;
			oe_d = req_top.oe;
			out_d = req_top.out;
		end else if (req_mid.en) begin
			sel_d = SEL_MID;
			oe_d = req_mid.oe;
			out_d = req_mid.out;
		end else if (req_low.en) begin
			sel_d = SEL_LOW;
			oe_d = req_low.oe;
			out_d = req_low.out;
		end
	end

	// Registered so pad outputs stay glitch free; costs one cycle of latency
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sel <= SEL_GPIO; // see (RULE3)
			pad_oe <= 1'b0;
			pad_out <= 1'b0;
		end else begin
			sel <= sel_d;
			pad_oe <= oe_d;
			pad_out <= out_d;
		end
	end

	// ********************
	// Checks
	// ********************
	property p_top_wins;
		@(posedge clk_sys) disable iff (rst)
		req_top.en |=> (sel == SEL_TOP) && (pad_oe == $past(req_top.oe));
	endproperty
	a_top_wins: assert property (p_top_wins) else $error("top function not selected"); // see (RULE1)

	property p_gpio_fallback;
		@(posedge clk_sys) disable iff (rst)
		!(req_top.en || req_mid.en || req_low.en)
			|=> (sel == SEL_GPIO) && (pad_oe == $past(gpio_dir)) && (pad_out == $past(gpio_out));
	endproperty
	a_gpio_fallback: assert property (p_gpio_fallback) else $error("gpio fallback wrong"); // see (RULE15)

	property p_mid_over_low;
		@(posedge clk_sys) disable iff (rst)
		(!req_top.en && req_mid.en) |=> (sel == SEL_MID) && (pad_out == $past(req_mid.out));
	endproperty
	a_mid_over_low: assert property (p_mid_over_low) else $error("middle rank lost"); // see (RULE1)
endmodule
`default_nettype wire

// ===== test/pin_world.sv
// Partner: external pins with a pulled-up debug wire and a moving pattern on port A
`default_nettype none
module pin_world
	import pin_mux_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Pads from the multiplexer
	input wire pad_drive_t port_a_pin,
	input wire logic debug_pin_oe,
	input wire logic debug_pin_out,
	// Host strap drive
	input wire logic host_drv,
	input wire logic host_val,
	// Pin levels back
	output logic [7:0] port_a_pin_in,
	output logic debug_pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Undriven pins follow a pattern that moves every cycle so a stale value cannot pass
	logic [7:0] ext_q = 8'h3c;
	always @(negedge clk_sys) begin
		ext_q <= {ext_q[6:0], ext_q[7] ^ ext_q[5] ^ ext_q[4] ^ ext_q[3]};
	end
	assign port_a_pin_in = (port_a_pin.oe & port_a_pin.out) | (~port_a_pin.oe & ext_q);
	// Strap level from host while it drives, pull-up once released
	assign debug_pin_in = debug_pin_oe ? debug_pin_out : (host_drv ? host_val : 1'b1);
endmodule
`default_nettype wire

// ===== test/port_pin_function_priority_mux_bench.sv
// Bench: random priority checks of the pin multiplexer against a reference model
`default_nettype none
module port_pin_function_priority_mux_bench
	import pin_mux_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	localparam fn_req_t NO = '0;
	logic clk_sys = 1'b0;
	logic rst = 1'b0;
	gpio_cfg_t ga, gb, gh, gm, gp;
	logic [39:0] fe, fo;
	logic [3:0] be, bo;
	logic ie, ne, d_in, d_out, d_oe, msel, d_rx, tx_out, tx_oe, hdrv, hval, strap, quiet;
	fn_req_t pic, frc, sck, ss, mosi, miso, txh, rxh, txm, rxm;
	fn_req_t [3:2] t1, t0;
	fn_req_t [7:0] pw;
	pad_drive_t pa, pb, ph, pm, pp;
	logic [7:0] a_in, a_lvl, ah1, ah2;
	logic dh1, dh2;
	integer seed = 32'h48f0;
	integer failures = 0;
	integer check_count = 0;
	integer run = 0;

	// ****
	// Reference model
	// ****
	function automatic logic [39:0] r40();
		return 40'({$random(seed), $random(seed)});
	endfunction
	function automatic fn_req_t rq();
		logic [31:0] r;
		r = $random(seed);
		return fn_req_t'({r[0] & r[1] & ~quiet, r[2], r[3]});
	endfunction
	function automatic fn_req_t lcd(input int k);
		return '{fe[k], 1'b1, fo[k]};
	endfunction
	function automatic logic [1:0] pick(input fn_req_t a, b, c, input logic d, q);
		if (a.en) return {a.oe, a.out};
		if (b.en) return {b.oe, b.out};
		if (c.en) return {c.oe, c.out};
		return {d, q};
	endfunction
	task automatic cmp(input logic [15:0] got, exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pads();
		logic [1:0] e[5];
		logic [7:0] eo[5], ev[5];
		for (int i = 0; i < 8; i++) begin
			e[0] = pick(lcd(29 + i), i == 3 ? pic : i == 1 ? fn_req_t'{ne, 1'b0, 1'b0} :
				i == 0 ? fn_req_t'{ie, 1'b0, 1'b0} : NO, NO, ga.dir[i], ga.data[i]);
			e[1] = pick(i > 3 ? fn_req_t'{be[i - 4], 1'b1, bo[i - 4]} : lcd(i == 0 ? 28 : 36 + i),
				NO, NO, gb.dir[i], gb.data[i]);
			e[2] = pick(lcd(19 + i), i == 3 ? ss : i == 2 ? sck : i == 1 ? txh : i == 0 ? rxh : NO,
				i == 2 ? frc : i == 1 ? mosi : i == 0 ? miso : NO, gh.dir[i], gh.data[i]);
			e[3] = i > 3 ? {gm.dir[i], gm.data[i]} : pick(i == 3 ? t1[3] : i == 2 ? t1[2] :
				i == 1 ? txm : rxm, i == 3 ? pw[7] : i == 2 ? pw[6] : i == 1 ? t0[3] : t0[2],
				i == 1 ? pw[5] : i == 0 ? pw[4] : NO, gm.dir[i], gm.data[i]);
			e[4] = pick(lcd(i), pw[i], NO, gp.dir[i], gp.data[i]);
			for (int k = 0; k < 5; k++) begin
				eo[k][i] = e[k][1];
				ev[k][i] = e[k][1] & e[k][0];
			end
		end
		// Level of a pin not driven is of no interest, so it is masked
		cmp({pa.oe, pa.out & pa.oe}, {eo[0], ev[0]});
		cmp({pb.oe, pb.out & pb.oe}, {eo[1], ev[1]});
		cmp({ph.oe, ph.out & ph.oe}, {eo[2], ev[2]});
		cmp({pm.oe, pm.out & pm.oe}, {eo[3], ev[3]});
		cmp({pp.oe, pp.out & pp.oe}, {eo[4], ev[4]});
	endtask

	// ****
	// Stimulus
	// ****
	task automatic drive();
		fn_req_t t;
		ga = gpio_cfg_t'(16'(r40()));
		gb = gpio_cfg_t'(16'(r40()));
		gh = gpio_cfg_t'(16'(r40()));
		gm = gpio_cfg_t'(16'(r40()));
		gp = gpio_cfg_t'(16'(r40()));
		fe = r40() & r40() & r40() & {40{~quiet}};
		fo = r40();
		be = 4'(r40() & r40()) & {4{~quiet}};
		bo = 4'(r40());
		t = rq();
		ie = t.en;
		t = rq();
		ne = t.en;
		{pic, frc, sck, ss, mosi, miso} = {rq(), rq(), rq(), rq(), rq(), rq()};
		{txh, rxh, txm, rxm, t1, t0} = {rq(), rq(), rq(), rq(), rq(), rq(), rq(), rq()};
		for (int i = 0; i < 8; i++) begin
			pw[i] = rq();
		end
		t = rq();
		tx_out = t.out;
		t = rq();
		tx_oe = t.oe & ~quiet;
	endtask
	task automatic step();
		@(negedge clk_sys);
		if (rst) begin
			cmp({pa.oe | pb.oe | ph.oe | pm.oe | pp.oe, pa.out | pb.out | pp.out}, 16'h0);
			cmp({14'h0, d_oe, msel}, 16'h0);
		end else if (run >= 2) begin
			pads();
			cmp({4'h0, d_oe, d_out & d_oe, d_rx, msel, a_lvl},
				{4'h0, tx_oe, tx_out & tx_oe, dh2, strap, ah2});
			if (quiet) cmp({pa.oe, pp.oe}, {ga.dir, gp.dir});
		end
		run = rst ? 0 : run + 1;
		drive();
	endtask
	task automatic do_reset(input logic s);
		strap = s;
		hval = s;
		hdrv = 1'b1;
		quiet = 1'b1;
		rst = 1'b1;
		repeat (10) step();
		rst = 1'b0;
		repeat (4) step();
		hdrv = 1'b0;
		repeat (20) step();
		quiet = 1'b0;
		repeat (1500) step();
	endtask
	task automatic end_of_test();
		if (failures == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		ah2 = ah1;
		ah1 = a_in;
		dh2 = dh1;
		dh1 = d_in;
	end
	initial begin
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		quiet = 1'b1;
		hdrv = 1'b1;
		hval = 1'b0;
		strap = 1'b0;
		drive();
		// Reset rises on an edge of its own so the async branches see it
		@(negedge clk_sys);
		do_reset(1'b0);
		do_reset(1'b1);
		end_of_test();
	end

	port_pin_function_priority_mux DUT (.clk_sys(clk_sys), .rst(rst), .gpio_a(ga), .gpio_b(gb),
		.gpio_h(gh), .gpio_m(gm), .gpio_p(gp), .lcd_frontplane_en(fe), .lcd_frontplane_out(fo),
		.lcd_backplane_en(be), .lcd_backplane_out(bo), .irq_in_en(ie), .nonmaskable_irq_en(ne),
		.periodic_irq_clock_out(pic), .free_running_clock_out(frc), .spi_clock(sck),
		.spi_slave_select(ss), .spi_mosi(mosi), .spi_miso(miso), .serial1_transmit_h(txh),
		.serial1_receive_h(rxh), .serial1_transmit_m(txm), .serial1_receive_m(rxm),
		.timer1_channel(t1), .timer0_channel(t0), .pwm_channel(pw), .port_a_pin(pa),
		.port_b_pin(pb), .port_h_pin(ph), .port_m_pin(pm), .port_p_pin(pp), .port_a_pin_in(a_in),
		.port_a_level(a_lvl), .debug_pin_in(d_in), .debug_pin_out(d_out), .debug_pin_oe(d_oe),
		.mode_select_input(msel), .debug_rx(d_rx), .debug_tx_out(tx_out), .debug_tx_oe(tx_oe));
	pin_world ext (.clk_sys(clk_sys), .port_a_pin(pa), .debug_pin_oe(d_oe), .debug_pin_out(d_out),
		.host_drv(hdrv), .host_val(hval), .port_a_pin_in(a_in), .debug_pin_in(d_in));
endmodule
`default_nettype wire
